// file: rtl/vafs_consts.svh
// Purpose: constants of the valve amplifier fault supervisor
// Assumes: 200 MHz clock
// Notes: codes of signal types and inputs; field positions
`ifndef VAFS_CONSTS_SVH
`define VAFS_CONSTS_SVH
`define VAFS_DATA_W 12
`define VAFS_FULL_SCALE 12'hFFF
`define VAFS_NUM_DIN 8
`define VAFS_NUM_DOUT 2
`define VAFS_ENABLE_BIT 2
`define VAFS_SIG_0_5V 3'h0
`define VAFS_SIG_0_8V 3'h1
`define VAFS_SIG_0_10V 3'h2
`define VAFS_SIG_0_20MA 3'h3
`define VAFS_SIG_4_20MA 3'h4
`define VAFS_IN_V1 2'h0
`define VAFS_IN_I2 2'h1
`define VAFS_IN_V3 2'h2
`define VAFS_IN_I4 2'h3
`define VAFS_UV_THRESH_DEF 12'h2E0
`define VAFS_LIVE_ZERO_DEF 12'h333
`define VAFS_OPEN_THRESH_DEF 12'h071
`define VAFS_F_POWER 0
`define VAFS_F_CB_SUPPLY 1
`define VAFS_F_CB_IN_A 2
`define VAFS_F_CB_IN_B 3
`define VAFS_F_SOL_A 4
`define VAFS_F_SOL_B 5
`define VAFS_F_MEMORY 6
`define VAFS_NUM_FAULTS 7
`endif

// file: rtl/vafs_pkg.sv
// Purpose: types of the valve amplifier fault supervisor
// Assumes: vafs_consts.svh
// Notes: structs carry configuration and measurements; faults are a 7-bit vector
`include "vafs_consts.svh"
package vafs_pkg;
    typedef enum logic [1:0] {
        VAFS_MODE_1,
        VAFS_MODE_2,
        VAFS_MODE_3,
        VAFS_MODE_4
    } vafs_mode_t;
    typedef struct packed {
        vafs_mode_t mode;
        logic cable_break_en;
        logic [2:0] sig_type;
        logic [1:0] input_a;
        logic [1:0] input_b;
        logic invert;
    } vafs_cfg_t;
    typedef struct packed {
        logic [11:0] supply;
        logic [11:0] ana_a;
        logic [11:0] ana_b;
        logic [11:0] ctrl_a;
        logic [11:0] ctrl_b;
        logic [11:0] cur_a;
        logic [11:0] cur_b;
    } vafs_meas_t;
    typedef logic [6:0] vafs_faults_t;
endpackage

// file: rtl/vafs_sync.sv
// Purpose: two-stage synchroniser for a bus of pin levels
// Assumes: levels only, no multi-bit coherence needed
// Notes: first stage is read only by the second
`timescale 1ns/100ps
module vafs_sync #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// file: rtl/vafs_param_mem.sv
// Purpose: working copy of stored parameter words
// Assumes: factory set written in through the write port
// Notes: read data registered
`timescale 1ns/100ps
module vafs_param_mem #(
    parameter int DEPTH = 16,
    parameter int AW = 4,
    parameter int DW = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem_r [DEPTH];
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem_r[rd_addr];
        end
    end
endmodule

// file: rtl/vafs_top.sv
// Purpose: configuration and fault supervision of a two-solenoid amplifier
// Assumes: analog values arrive digitised on the clock; pins are async
// Notes: the serial protocol layer sits outside; it drives the strobes
`timescale 1ns/100ps
`include "vafs_consts.svh"
module vafs_top #(
    parameter int DW = `VAFS_DATA_W,
    parameter int NDI = `VAFS_NUM_DIN,
    parameter int NDO = `VAFS_NUM_DOUT,
    parameter logic [11:0] UV_THRESH = `VAFS_UV_THRESH_DEF,
    parameter logic [11:0] LIVE_ZERO = `VAFS_LIVE_ZERO_DEF,
    parameter logic [11:0] OPEN_THRESH = `VAFS_OPEN_THRESH_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cfg_wr,
    input wire vafs_pkg::vafs_cfg_t cfg_in,
    output vafs_pkg::vafs_cfg_t cfg_out,
    output logic cfg_rejected,
    input wire logic [NDI-1:0] din_pin,
    input wire logic [NDI-1:0] force_en,
    input wire logic [NDI-1:0] force_val,
    input wire logic [NDO-1:0] dout_req,
    output logic [NDI-1:0] din_state,
    output logic [NDO-1:0] dout_pin,
    output logic [NDO-1:0] dout_state,
    input wire vafs_pkg::vafs_meas_t meas_in,
    input wire logic gen_supply_break,
    input wire logic [11:0] preset_a,
    input wire logic [11:0] preset_b,
    input wire logic sol_open_a,
    input wire logic sol_open_b,
    input wire logic mem_verify_fail,
    input wire logic store_params,
    input wire logic default_load,
    output logic [11:0] cmd_a,
    output logic [11:0] cmd_b,
    output logic block_a,
    output logic block_b,
    input wire logic diag_req,
    output vafs_pkg::vafs_faults_t diag_snapshot,
    output logic diag_valid,
    input wire logic values_req,
    output vafs_pkg::vafs_meas_t values_snapshot,
    output logic values_valid,
    input wire logic [3:0] param_rd_addr,
    output logic [15:0] param_rd_data,
    output logic default_done
);
    localparam vafs_pkg::vafs_cfg_t CFG_RESET = '{
        mode: vafs_pkg::VAFS_MODE_1, cable_break_en: 1'b0,
        sig_type: `VAFS_SIG_0_10V, input_a: `VAFS_IN_V1,
        input_b: `VAFS_IN_V3, invert: 1'b0};

    // configuration check
    logic sig_is_current;
    logic inp_a_current;
    logic inp_b_current;
    logic type_ok;
    logic inputs_ok;
    logic cfg_ok;
    vafs_pkg::vafs_cfg_t cfg_r;
    assign sig_is_current = (cfg_in.sig_type == `VAFS_SIG_0_20MA) ||
                            (cfg_in.sig_type == `VAFS_SIG_4_20MA);
    assign inp_a_current = (cfg_in.input_a == `VAFS_IN_I2) ||
                           (cfg_in.input_a == `VAFS_IN_I4);
    assign inp_b_current = (cfg_in.input_b == `VAFS_IN_I2) ||
                           (cfg_in.input_b == `VAFS_IN_I4);
    // mode 2 carries offset; voltage only there is a small choice
    assign type_ok = (cfg_in.sig_type <= `VAFS_SIG_4_20MA) &&
        !(cfg_in.mode == vafs_pkg::VAFS_MODE_2 && sig_is_current);
    assign inputs_ok = (inp_a_current == sig_is_current) &&
                       (inp_b_current == sig_is_current);
    // also refused here so a faulty configurer cannot share an input
    assign cfg_ok = type_ok && inputs_ok &&
                    (cfg_in.input_a != cfg_in.input_b);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_r <= CFG_RESET;
            cfg_rejected <= 1'b0;
        end else if (cfg_wr) begin
            if (cfg_ok) begin
                cfg_r <= cfg_in;
            end
            cfg_rejected <= !cfg_ok;
        end
    end
    assign cfg_out = cfg_r;

    // digital inputs
    logic [NDI-1:0] din_sync;
    logic [NDI-1:0] din_eff;
    vafs_sync #(.W(NDI)) u_din_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d(din_pin),
        .q(din_sync)
    );
    genvar gi;
    generate
        for (gi = 0; gi < NDI; gi++) begin : g_din
            assign din_eff[gi] = force_en[gi] ? force_val[gi]
                                              : din_sync[gi];
        end
    endgenerate

    logic enable_now;
    logic enable_prev_r;
    logic reenable;
    assign enable_now = din_eff[`VAFS_ENABLE_BIT];
    assign reenable = enable_now && !enable_prev_r;

    // fault detection
    logic is_live_zero;
    logic cb_in_a;
    logic cb_in_b;
    logic [6:0] fault_evt;
    logic [6:0] fault_r;
    logic [6:0] fault_nxt;
    assign is_live_zero = cfg_r.sig_type == `VAFS_SIG_4_20MA;
    assign cb_in_a = is_live_zero && meas_in.ana_a < LIVE_ZERO;
    assign cb_in_b = is_live_zero && meas_in.ana_b < LIVE_ZERO;
    assign fault_evt[`VAFS_F_POWER] = meas_in.supply < UV_THRESH;
    assign fault_evt[`VAFS_F_CB_SUPPLY] =
        cfg_r.cable_break_en && gen_supply_break;
    assign fault_evt[`VAFS_F_CB_IN_A] = cfg_r.cable_break_en && cb_in_a;
    assign fault_evt[`VAFS_F_CB_IN_B] =
        cfg_r.cable_break_en && cb_in_b;
    assign fault_evt[`VAFS_F_SOL_A] =
        sol_open_a && cmd_a > OPEN_THRESH;
    assign fault_evt[`VAFS_F_SOL_B] = sol_open_b && cmd_b > OPEN_THRESH;
    assign fault_evt[`VAFS_F_MEMORY] = mem_verify_fail;

    // set wins over clear; memory bit ignores re-enable
    assign fault_nxt[5:0] = fault_evt[5:0] |
                            (reenable ? 6'h00 : fault_r[5:0]);
    assign fault_nxt[6] = fault_evt[6] |
                          (store_params ? 1'b0 : fault_r[6]);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fault_r <= 7'h00;
            // an enable already high at reset is not a re-enable edge
            enable_prev_r <= 1'b1;
        end else begin
            fault_r <= fault_nxt;
            enable_prev_r <= enable_now;
        end
    end

    // output command and blocking
    logic blk_all;
    logic blk_a_nxt;
    logic blk_b_nxt;
    logic [11:0] map_a;
    logic [11:0] map_b;
    assign blk_all = fault_r[`VAFS_F_POWER] | fault_r[`VAFS_F_CB_SUPPLY] |
                     fault_r[`VAFS_F_MEMORY];
    assign blk_a_nxt = blk_all | fault_r[`VAFS_F_CB_IN_A] |
                       fault_r[`VAFS_F_SOL_A];
    assign blk_b_nxt = blk_all | fault_r[`VAFS_F_CB_IN_B] |
                       fault_r[`VAFS_F_SOL_B];
    assign map_a = cfg_r.invert ? (`VAFS_FULL_SCALE - preset_a)
                                : preset_a;
    assign map_b = cfg_r.invert ? (`VAFS_FULL_SCALE - preset_b)
                                : preset_b;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cmd_a <= 12'h000;
            cmd_b <= 12'h000;
            block_a <= 1'b1;
            block_b <= 1'b1;
            dout_pin <= '0;
            dout_state <= '0;
            din_state <= '0;
        end else begin
            // hold off the solenoid while blocked
            cmd_a <= blk_a_nxt ? 12'h000 : map_a;
            cmd_b <= blk_b_nxt ? 12'h000 : map_b;
            block_a <= blk_a_nxt;
            block_b <= blk_b_nxt;
            dout_pin <= dout_req;
            dout_state <= dout_req;
            din_state <= din_eff;
        end
    end

    // snapshots taken once per request, no streaming
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            diag_snapshot <= 7'h00;
            diag_valid <= 1'b0;
            values_snapshot <= '0;
            values_valid <= 1'b0;
        end else begin
            diag_valid <= diag_req;
            values_valid <= values_req;
            if (diag_req) begin
                diag_snapshot <= fault_r;
            end
            if (values_req) begin
                values_snapshot <= meas_in;
            end
        end
    end

    // factory default load into working parameter memory
    typedef enum logic [0:0] {ST_IDLE, ST_LOAD} vafs_ld_t;
    vafs_ld_t ld_r;
    logic [3:0] ld_addr_r;
    logic [15:0] factory_word;
    logic ld_wr;
    // factory set is a simple fixed pattern; real values are loaded at build
    assign factory_word = {12'h000, ld_addr_r};
    assign ld_wr = ld_r == ST_LOAD;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ld_r <= ST_IDLE;
            ld_addr_r <= 4'h0;
            default_done <= 1'b0;
        end else begin
            default_done <= 1'b0;
            unique case (ld_r)
                ST_IDLE: begin
                    if (default_load) begin
                        ld_r <= ST_LOAD;
                        ld_addr_r <= 4'h0;
                    end
                end
                ST_LOAD: begin
                    ld_addr_r <= ld_addr_r + 4'h1;
                    if (ld_addr_r == 4'hF) begin
                        ld_r <= ST_IDLE;
                        default_done <= 1'b1;
                    end
                end
            endcase
        end
    end

    vafs_param_mem #(.DEPTH(16), .AW(4), .DW(16)) u_mem (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(ld_wr),
        .wr_addr(ld_addr_r),
        .wr_data(factory_word),
        .rd_addr(param_rd_addr),
        .rd_data(param_rd_data)
    );

    // checks
    property p_uv_block;
        @(posedge clock) disable iff (!rst_n)
        (meas_in.supply < UV_THRESH) |=> ##1 (block_a && block_b);
    endproperty
    a_uv_block: assert property (p_uv_block)
        else $error("undervoltage did not block outputs");

    property p_fault_sticky;
        @(posedge clock) disable iff (!rst_n)
        (fault_r[`VAFS_F_POWER] && !reenable) |=> fault_r[`VAFS_F_POWER];
    endproperty
    a_fault_sticky: assert property (p_fault_sticky)
        else $error("power fault dropped without re-enable");

    property p_mem_keep;
        @(posedge clock) disable iff (!rst_n)
        (fault_r[6] && !store_params) |=> fault_r[6];
    endproperty
    a_mem_keep: assert property (p_mem_keep)
        else $error("memory fault cleared without store");

    property p_cb_off;
        @(posedge clock) disable iff (!rst_n)
        !cfg_r.cable_break_en |=> !fault_r[`VAFS_F_CB_SUPPLY] ||
            $past(fault_r[`VAFS_F_CB_SUPPLY]);
    endproperty
    a_cb_off: assert property (p_cb_off)
        else $error("cable break set while supervision off");

    property p_open_low;
        @(posedge clock) disable iff (!rst_n)
        (sol_open_a && cmd_a <= OPEN_THRESH && !fault_r[4] && !reenable)
            |=> !fault_r[4];
    endproperty
    a_open_low: assert property (p_open_low)
        else $error("open solenoid flagged below threshold");

    property p_inv;
        @(posedge clock) disable iff (!rst_n)
        (cfg_r.invert && !blk_a_nxt && preset_a == 12'h000)
            |=> cmd_a == `VAFS_FULL_SCALE;
    endproperty
    a_inv: assert property (p_inv)
        else $error("inversion did not give full current");

    property p_diag;
        @(posedge clock) disable iff (!rst_n)
        diag_req |=> diag_valid && diag_snapshot == $past(fault_r);
    endproperty
    a_diag: assert property (p_diag)
        else $error("diagnostic snapshot mismatch");

    property p_cfg_same;
        @(posedge clock) disable iff (!rst_n)
        (cfg_wr && cfg_in.input_a == cfg_in.input_b) |=>
            cfg_rejected && cfg_r == $past(cfg_r);
    endproperty
    a_cfg_same: assert property (p_cfg_same)
        else $error("shared input accepted");

    property p_force;
        @(posedge clock) disable iff (!rst_n)
        force_en[0] |=> din_state[0] == $past(force_val[0]);
    endproperty
    a_force: assert property (p_force)
        else $error("forced input not reported");

    sequence s_ld_start;
        ld_r == ST_IDLE && default_load;
    endsequence
    property p_default;
        @(posedge clock) disable iff (!rst_n)
        s_ld_start |=> ##16 default_done;
    endproperty
    a_default: assert property (p_default)
        else $error("default load did not finish in 17 cycles");
endmodule

// file: sim/vafs_pc_model.sv
// Purpose: configuring party beside the supervisor
// Assumes: bench asks for writes and enable toggles by one-cycle pulses
// Notes: enable input is always held by software so it can be toggled
`timescale 1ns/100ps
module vafs_pc_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cfg_go,
    input wire vafs_pkg::vafs_cfg_t cfg_req,
    input wire logic toggle_go,
    input wire logic [7:0] fen_req,
    input wire logic [7:0] fval_req,
    output logic cfg_wr,
    output vafs_pkg::vafs_cfg_t cfg_in,
    output logic pc_refused,
    output logic [7:0] force_en,
    output logic [7:0] force_val
);
    logic en_r;
    logic [1:0] off_cnt_r;
    wire same_in = cfg_req.input_a == cfg_req.input_b;
    // enable stays forced so a pin glitch cannot clear faults
    assign force_en = fen_req | 8'h04;
    assign force_val = {fval_req[7:3], en_r, fval_req[1:0]};
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_wr <= 1'h0;
            cfg_in <= '0;
            pc_refused <= 1'h0;
            en_r <= 1'h1;
            off_cnt_r <= 2'h0;
        end else begin
            cfg_wr <= cfg_go && !same_in;
            if (cfg_go) begin
                pc_refused <= same_in;
                cfg_in <= cfg_req;
            end
            if (toggle_go) begin
                en_r <= 1'h0;
                off_cnt_r <= 2'h3;
            end else if (off_cnt_r != 2'h0) begin
                off_cnt_r <= off_cnt_r - 2'h1;
                if (off_cnt_r == 2'h1) begin
                    en_r <= 1'h1;
                end
            end
        end
    end
endmodule

// file: sim/testbench.sv
// Purpose: self-checking bench of the fault supervisor
// Assumes: fixed hand-over latencies, waits bounded elsewhere
// Notes: config cases in a table, faults by event masks
`timescale 1ns/100ps
module testbench;
    typedef struct packed {
        vafs_pkg::vafs_cfg_t c;
        logic pcref;
        logic rej;
    } vafs_row_t;
    logic clock, rst_n, cfg_wr, cfg_rejected, cfg_go, toggle_go, pc_refused;
    vafs_pkg::vafs_cfg_t cfg_in, cfg_out, cfg_req, exp_cfg;
    logic [7:0] din_pin, force_en, force_val, din_state, fen_req, fval_req;
    logic [1:0] dout_req, dout_pin, dout_state;
    vafs_pkg::vafs_meas_t meas_in, values_snapshot;
    logic gen_supply_break, sol_open_a, sol_open_b, mem_verify_fail;
    logic store_params, default_load, block_a, block_b, exp_rej;
    logic [11:0] preset_a, preset_b, cmd_a, cmd_b;
    logic diag_req, diag_valid, values_req, values_valid, default_done;
    vafs_pkg::vafs_faults_t diag_snapshot;
    logic [3:0] param_rd_addr;
    logic [15:0] param_rd_data;
    int fails, checked, i;
    vafs_row_t rows [8];
    vafs_top u_vafs_top (.*);
    vafs_pc_model u_vafs_pc_model (.*);
    always #2.5 clock = ~clock;
    task chk(input logic [83:0] got, input logic [83:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task chkb(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task results;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    function vafs_pkg::vafs_cfg_t mk(input logic [1:0] m, input logic cb,
        input logic [2:0] s, input logic [1:0] a, b, input logic v);
        mk = {m, cb, s, a, b, v};
    endfunction
    task cfg(input vafs_pkg::vafs_cfg_t c);
        @(posedge clock);
        cfg_req <= c;
        cfg_go <= 1'h1;
        @(posedge clock);
        cfg_go <= 1'h0;
        repeat (3) @(posedge clock);
        #1;
    endtask
    // w: 0 diagnostics, 1 values, 2 factory load
    task req(input int w);
        int n;
        @(posedge clock);
        diag_req <= w == 0;
        values_req <= w == 1;
        default_load <= w == 2;
        @(posedge clock);
        {diag_req, values_req, default_load} <= 3'h0;
        #1;
        n = 0;
        while (n < 30 && !(w == 0 ? diag_valid === 1'h1 : w == 1 ?
               values_valid === 1'h1 : default_done === 1'h1)) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 30) begin
            fails++;
            $display("Error at %0t: no answer to request %0h", $time, w);
        end
    endtask
    task evt(input logic [6:0] m, input logic on);
        @(posedge clock);
        meas_in.supply <= (on && m[0]) ? 12'h100 : 12'hFFF;
        gen_supply_break <= on && m[1];
        meas_in.ana_a <= (on && m[2]) ? 12'h100 : 12'hFFF;
        sol_open_b <= on && m[3];
        mem_verify_fail <= on && m[4];
        meas_in.ana_b <= (on && m[5]) ? 12'h100 : 12'hFFF;
        sol_open_a <= on && m[6];
    endtask
    task flt(input logic [6:0] m, input logic [6:0] e, input logic ea, eb);
        evt(m, 1'h1);
        repeat (4) @(posedge clock);
        req(0);
        chk(diag_snapshot, e);
        chkb(block_a, ea);
        chkb(block_b, eb);
        chk(cmd_a, ea ? 12'h000 : preset_a);
        chk(cmd_b, eb ? 12'h000 : preset_b);
        evt(m, 1'h0);
        repeat (3) @(posedge clock);
        req(0);
        chk(diag_snapshot, e);
        @(posedge clock);
        toggle_go <= 1'h1;
        @(posedge clock);
        toggle_go <= 1'h0;
        repeat (10) @(posedge clock);
        req(0);
        chk(diag_snapshot, {m[4], 6'h00});
        if (m[4]) begin
            @(posedge clock);
            store_params <= 1'h1;
            @(posedge clock);
            store_params <= 1'h0;
            repeat (3) @(posedge clock);
            req(0);
            chk(diag_snapshot, 7'h00);
        end
        chkb(block_a, 1'h0);
        chkb(block_b, 1'h0);
        $display("fault case %0h done", m);
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        results();
    end
    initial begin
        {clock, rst_n, cfg_go, toggle_go, gen_supply_break} = 5'h00;
        {sol_open_a, sol_open_b, mem_verify_fail, store_params} = 4'h0;
        {default_load, diag_req, values_req} = 3'h0;
        {din_pin, fen_req, fval_req, dout_req, param_rd_addr} = 30'h0;
        cfg_req = '0;
        preset_a = 12'hFFF;
        preset_b = 12'hFFF;
        meas_in = {12'hFFF, 12'hFFF, 12'hFFF, 12'h111, 12'h222, 12'h333,
                   12'h444};
        rows[0] = '{mk(2'h0, 1'h0, 3'h0, 2'h0, 2'h2, 1'h0), 1'h0, 1'h0};
        rows[1] = '{mk(2'h2, 1'h0, 3'h1, 2'h2, 2'h0, 1'h0), 1'h0, 1'h0};
        rows[2] = '{mk(2'h2, 1'h1, 3'h3, 2'h1, 2'h3, 1'h0), 1'h0, 1'h0};
        rows[3] = '{mk(2'h1, 1'h0, 3'h3, 2'h1, 2'h3, 1'h0), 1'h0, 1'h1};
        rows[4] = '{mk(2'h0, 1'h0, 3'h5, 2'h0, 2'h2, 1'h0), 1'h0, 1'h1};
        rows[5] = '{mk(2'h0, 1'h0, 3'h2, 2'h1, 2'h2, 1'h0), 1'h0, 1'h1};
        rows[6] = '{mk(2'h0, 1'h0, 3'h0, 2'h0, 2'h0, 1'h0), 1'h1, 1'h0};
        rows[7] = '{mk(2'h3, 1'h1, 3'h4, 2'h1, 2'h3, 1'h0), 1'h0, 1'h0};
        exp_cfg = mk(2'h0, 1'h0, 3'h2, 2'h0, 2'h2, 1'h0);
        exp_rej = 1'h0;
        repeat (10) @(posedge clock);
        #1;
        chk(cfg_out, exp_cfg);
        chk({block_a, block_b, cmd_a, cmd_b}, {2'h3, 24'h0});
        @(posedge clock);
        rst_n <= 1'h1;
        $display("reset test done");
        for (i = 0; i < 8; i++) begin
            cfg(rows[i].c);
            if (!rows[i].pcref) exp_rej = rows[i].rej;
            if (!rows[i].pcref && !rows[i].rej) exp_cfg = rows[i].c;
            chk(cfg_out, exp_cfg);
            chkb(cfg_rejected, exp_rej);
            chkb(pc_refused, rows[i].pcref);
        end
        $display("configuration test done");
        @(posedge clock);
        din_pin <= 8'h5A;
        dout_req <= 2'h2;
        repeat (4) @(posedge clock);
        #1;
        chk(din_state, 8'h5E);
        chk({dout_pin, dout_state}, 4'hA);
        @(posedge clock);
        fen_req <= 8'h03;
        fval_req <= 8'h01;
        dout_req <= 2'h1;
        repeat (2) @(posedge clock);
        #1;
        chk(din_state, 8'h5D);
        chk({dout_pin, dout_state}, 4'h5);
        $display("digital test done");
        req(1);
        chk(values_snapshot, meas_in);
        chk(cmd_a, preset_a);
        $display("values test done");
        flt(7'h01, 7'h01, 1'h1, 1'h1);
        flt(7'h02, 7'h02, 1'h1, 1'h1);
        flt(7'h04, 7'h04, 1'h1, 1'h0);
        flt(7'h08, 7'h20, 1'h0, 1'h1);
        flt(7'h10, 7'h40, 1'h1, 1'h1);
        flt(7'h09, 7'h21, 1'h1, 1'h1);
        flt(7'h20, 7'h08, 1'h0, 1'h1);
        flt(7'h40, 7'h10, 1'h1, 1'h0);
        // command settles below the threshold before the open is shown
        @(posedge clock);
        preset_a <= 12'h050;
        repeat (2) @(posedge clock);
        sol_open_a <= 1'h1;
        repeat (4) @(posedge clock);
        req(0);
        chk(diag_snapshot, 7'h00);
        chkb(block_a, 1'h0);
        @(posedge clock);
        sol_open_a <= 1'h0;
        preset_a <= 12'hFFF;
        $display("open threshold test done");
        req(2);
        for (i = 0; i < 16; i++) begin
            @(posedge clock);
            param_rd_addr <= 4'(i);
            repeat (2) @(posedge clock);
            #1;
            chk(param_rd_data, 16'(i));
        end
        $display("factory load test done");
        cfg(mk(2'h3, 1'h0, 3'h4, 2'h1, 2'h3, 1'h1));
        evt(7'h02, 1'h1);
        preset_a <= 12'h100;
        repeat (5) @(posedge clock);
        req(0);
        chk(diag_snapshot, 7'h00);
        chk(cmd_a, 12'hEFF);
        @(posedge clock);
        preset_a <= 12'h000;
        repeat (4) @(posedge clock);
        #1;
        chk(cmd_a, 12'hFFF);
        evt(7'h02, 1'h0);
        $display("inversion test done");
        results();
    end
endmodule
